// File: reloadable_split_timer.sv
/*
 * Reloadable split timer: one 32-bit or two 16-bit counters behind an APB slave.
 * Assumes pclk-domain APB master; timer pins are asynchronous and are resynchronised here.
 */
// Local design decisions: register access over APB and the placing of the registers.
// Contract
// - Prescaler divides the timer clock by any value from 1 to 4096.
// - One-shot mode counts up to terminal value, then stops.
// - Continuous mode counts to terminal value, reloads and repeats on its own.
// - Counter mode advances on input pin edges, not clock cycles.
// - PWM holds level to first value, toggled level to terminal, repeats.
// - Capture mode snapshots the count on an input pin edge.
// - Compare mode toggles the output when the count passes terminal.
// - Gated mode counts only while the input pin is asserted.
// - Capture/compare counts while asserted, captures on deassertion.
// - Count advances from timer clock, pin stimulus, or both, by mode.
// - Reads of timer_count return the live count at any time.
// - A period ends on the timer clock following its end condition.
// - Each period end sets its flag and requests interrupt if enabled; capture mode reloads at terminal without setting the flag.
// - Most modes reload the count with one at each period end.
// - Reset clears the count to zero, so first period is longer.
// - Both 32-bit arrangements take control from the lower_timer fields.
// - Single 16-bit runs lower_timer only, ignoring upper_timer fields.
// - Dual 16-bit: upper fields drive bits 31:16, lower drive 15:0.
// - In dual 16-bit the upper_timer can run on its own.
// - Control registers duplicate fields in lower and upper 16 bits.
// - Low-power instances keep running and can wake the device.
// - Asynchronous pin events are latched on the next timer clock tick; the code samples the pin level at each tick, missing shorter pulses.
`timescale 1ns/10ps
module reloadable_split_timer
    import split_timer_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timer pins: index 0 lower_timer, index 1 upper_timer
    input wire logic [1:0] timer_in,
    output logic [1:0] timer_out,
    // Events
    output logic irq,
    output logic wake
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [31:0] count;
        logic [31:0] compare;
        logic [31:0] pwidth;
        logic [31:0] ctrl;
        logic [31:0] divide;
        logic [1:0] arrange;
        logic [1:0] flag;
        logic [1:0] pin_out;
        logic [1:0] meta;
        logic [1:0] sync;
        logic [1:0] prev;
        logic [1:0][DIV_W-1:0] presc;
        logic [31:0] rdata;
        logic slverr;
    } state_t;

    state_t s;
    state_t next_s;

    // ****************************************************************
    // One timer step for a given mode
    // ****************************************************************
    function automatic step_t step(input logic [31:0] cnt, input logic [31:0] term, input logic [31:0] pw,
                                   input logic [15:0] c, input logic tick, input logic lvl,
                                   input logic prev, input logic outb, input logic narrow);
        step_t r;
        logic [31:0] inc;
        logic hit;
        logic on;
        logic was_on;
        r.cnt = cnt;
        r.pw = pw;
        r.outb = outb;
        r.flag = 1'b0;
        r.stop = 1'b0;
        on = (lvl == c[CTRL_POL]);
        was_on = (prev == c[CTRL_POL]);
        inc = cnt + 32'h0000_0001;
        if (narrow) begin
            inc[31:16] = 16'h0000;
        end
        // End condition is seen here; the reload happens on this tick, the next after it was met
        hit = (cnt == term);
        if (tick) begin
            case (c[CTRL_MODE_LSB +: 4])
                MODE_ONESHOT: begin
                    if (hit) begin
                        r.cnt = COUNT_RELOAD;
                        r.flag = 1'b1;
                        r.stop = 1'b1;
                        r.outb = ~outb;
                    end else begin
                        r.cnt = inc;
                    end
                end
                MODE_CONTINUOUS: begin
                    if (hit) begin
                        r.cnt = COUNT_RELOAD;
                        r.flag = 1'b1;
                        r.outb = ~outb;
                    end else begin
                        r.cnt = inc;
                    end
                end
                MODE_COUNTER: begin
                    if (on && !was_on) begin
                        if (hit) begin
                            r.cnt = COUNT_RELOAD;
                            r.flag = 1'b1;
                            r.outb = ~outb;
                        end else begin
                            r.cnt = inc;
                        end
                    end
                end
                MODE_PWM: begin
                    if (hit) begin
                        r.cnt = COUNT_RELOAD;
                        r.flag = 1'b1;
                        r.outb = c[CTRL_POL];
                    end else begin
                        r.cnt = inc;
                        if (cnt == pw) begin
                            r.outb = ~c[CTRL_POL];
                        end
                    end
                end
                MODE_CAPTURE: begin
                    if (on && !was_on) begin
                        r.pw = cnt;
                        r.flag = 1'b1;
                        r.cnt = COUNT_RELOAD;
                    end else if (hit) begin
                        r.cnt = COUNT_RELOAD;
                    end else begin
                        r.cnt = inc;
                    end
                end
                MODE_COMPARE: begin
                    // Count keeps running and wraps; only the pin and flag react
                    r.cnt = inc;
                    if (hit) begin
                        r.flag = 1'b1;
                        r.outb = ~outb;
                    end
                end
                MODE_GATED: begin
                    if (on) begin
                        if (hit) begin
                            r.cnt = COUNT_RELOAD;
                            r.flag = 1'b1;
                        end else begin
                            r.cnt = inc;
                        end
                    end
                end
                MODE_CAPCMP: begin
                    if (on) begin
                        r.cnt = inc;
                    end else if (was_on) begin
                        r.pw = cnt;
                        r.flag = 1'b1;
                        r.cnt = COUNT_RELOAD;
                    end
                end
                default: begin
                    r.cnt = cnt;
                end
            endcase
        end
        return r;
    endfunction : step

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        logic wide;
        logic wr;
        logic [1:0] tick;
        logic [1:0] set;
        logic [1:0] clr;
        logic [15:0] c;
        step_t r;
        next_s = s;
        wide = (s.arrange == ARR_SINGLE32) || (s.arrange == ARR_CASCADE32);
        wr = psel && penable && pwrite;
        tick = 2'b00;
        set = 2'b00;
        clr = 2'b00;
        c = 16'h0000;
        r = '0;

        // ****************************************************************
        // Pin resynchronisers and prescalers
        // ****************************************************************
        // Two-stage resynchronisers for the pins
        next_s.meta = timer_in;
        next_s.sync = s.meta;

        for (int u = 0; u < 2; u++) begin
            c = s.ctrl[u*HALF_W +: HALF_W];
            // Prescaler: field value plus one is the division
            tick[u] = c[CTRL_EN] && (s.presc[u] == s.divide[u*HALF_W +: DIV_W]);
            if (!c[CTRL_EN] || tick[u]) begin
                next_s.presc[u] = '0;
            end else begin
                next_s.presc[u] = s.presc[u] + 12'h001;
            end
            // Pin level is taken only on a timer tick
            if (tick[u]) begin
                next_s.prev[u] = s.sync[u];
            end
        end

        // ****************************************************************
        // Timer steps
        // ****************************************************************
        // One step function serves every arrangement, so 16-bit and 32-bit behaviour cannot drift apart
        if (wide) begin
            // Upper half is one with the lower half here
            c = s.ctrl[HALF_W-1:0];
            r = step(s.count, s.compare, s.pwidth, c, tick[0], s.sync[0], s.prev[0], s.pin_out[0], 1'b0);
            next_s.count = r.cnt;
            next_s.pwidth = r.pw;
            next_s.pin_out[0] = r.outb;
            set[0] = r.flag;
            if (r.stop) begin
                next_s.ctrl[CTRL_EN] = 1'b0;
            end
        end else begin
            for (int u = 0; u < 2; u++) begin
                // Single 16-bit leaves upper half idle whatever its fields say
                if (u == 0 || s.arrange == ARR_DUAL16) begin
                    c = s.ctrl[u*HALF_W +: HALF_W];
                    r = step({16'h0000, s.count[u*HALF_W +: HALF_W]}, {16'h0000, s.compare[u*HALF_W +: HALF_W]},
                             {16'h0000, s.pwidth[u*HALF_W +: HALF_W]}, c, tick[u], s.sync[u], s.prev[u],
                             s.pin_out[u], 1'b1);
                    next_s.count[u*HALF_W +: HALF_W] = r.cnt[15:0];
                    next_s.pwidth[u*HALF_W +: HALF_W] = r.pw[15:0];
                    next_s.pin_out[u] = r.outb;
                    set[u] = r.flag;
                    if (r.stop) begin
                        next_s.ctrl[u*HALF_W + CTRL_EN] = 1'b0;
                    end
                end
            end
        end

        // ****************************************************************
        // Register writes, flags and read data
        // ****************************************************************
        // Software writes to count, pwidth and ctrl override hardware updates of the same cycle
        if (wr) begin
            if (paddr == OFF_COUNT) begin
                next_s.count = pwdata;
            end else if (paddr == OFF_COMPARE) begin
                next_s.compare = pwdata;
            end else if (paddr == OFF_PWIDTH) begin
                next_s.pwidth = pwdata;
            end else if (paddr == OFF_CTRL) begin
                next_s.ctrl = pwdata;
            end else if (paddr == OFF_DIVIDE) begin
                next_s.divide = pwdata;
            end else if (paddr == OFF_ARRANGE) begin
                next_s.arrange = pwdata[1:0];
            end else if (paddr == OFF_FLAGS) begin
                clr = {pwdata[HALF_W], pwdata[0]};
            end
        end
        // A period end in the clearing cycle is kept
        next_s.flag = (s.flag & ~clr) | set;

        // Read data is captured in the setup phase and shown in the access phase
        // Reads have no side effects, so the count may be polled while it runs
        if (psel && !penable) begin
            next_s.slverr = 1'b0;
            if (paddr == OFF_COUNT) begin
                next_s.rdata = s.count;
            end else if (paddr == OFF_COMPARE) begin
                next_s.rdata = s.compare;
            end else if (paddr == OFF_PWIDTH) begin
                next_s.rdata = s.pwidth;
            end else if (paddr == OFF_CTRL) begin
                next_s.rdata = s.ctrl;
            end else if (paddr == OFF_DIVIDE) begin
                next_s.rdata = s.divide;
            end else if (paddr == OFF_ARRANGE) begin
                next_s.rdata = {30'h0, s.arrange};
            end else if (paddr == OFF_FLAGS) begin
                next_s.rdata = {15'h0, s.flag[1], 15'h0, s.flag[0]};
            end else begin
                next_s.rdata = 32'h0000_0000;
                next_s.slverr = 1'b1;
            end
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.count <= COUNT_RESET;
            s.compare <= COMPARE_RESET;
            s.pwidth <= PWIDTH_RESET;
            s.ctrl <= CTRL_RESET;
            s.divide <= DIVIDE_RESET;
            s.arrange <= ARR_SINGLE32;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign prdata = s.rdata;
    assign pslverr = s.slverr;
    assign pready = 1'b1;
    assign timer_out = s.pin_out;
    assign irq = |(s.flag & {s.ctrl[HALF_W + CTRL_IE], s.ctrl[CTRL_IE]});
    // Needs no fast clock itself, so it can leave a sleeping system awake
    assign wake = |(s.flag & {s.ctrl[HALF_W + CTRL_WE], s.ctrl[CTRL_WE]});

endmodule : reloadable_split_timer

// File: reloadable_split_timer_assertions.sv
/* Port-level checker for the reloadable split timer.
   Assumes it is bound to reloadable_split_timer and sees only that module's ports. */
`timescale 1ns/10ps
module reloadable_split_timer_checker
    import split_timer_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and events
    input wire logic [1:0] timer_out,
    input wire logic irq,
    input wire logic wake
);
    // ****************************************
    // Software shadows
    // ****************************************
    // The count shadow is trusted only while every timer stays off
    logic wr_acc;
    logic rd_acc;
    logic bad_addr;
    logic [31:0] cmp_sh;
    logic [31:0] ctrl_sh;
    logic [31:0] cnt_sh;
    logic cnt_known;
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign bad_addr = paddr > OFF_FLAGS || paddr[1:0] != 2'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_sh <= COMPARE_RESET;
            ctrl_sh <= CTRL_RESET;
            cnt_sh <= COUNT_RESET;
            cnt_known <= 1'b1;
        end else if (wr_acc) begin
            if (paddr == OFF_COMPARE) cmp_sh <= pwdata;
            if (paddr == OFF_CTRL) begin
                ctrl_sh <= pwdata;
                cnt_known <= cnt_known && pwdata == 32'h0;
            end
            if (paddr == OFF_COUNT && ctrl_sh == 32'h0) begin
                cnt_sh <= pwdata;
                cnt_known <= 1'b1;
            end
        end
    end
    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready; pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_bad; psel && penable && bad_addr |-> pslverr && (pwrite || prdata == 32'h0); endproperty
    a_bad: assert property (p_bad) else $error("unmapped access not refused");
    property p_good; psel && penable && !bad_addr |-> !pslverr; endproperty
    a_good: assert property (p_good) else $error("mapped access refused");
    property p_cmp; rd_acc && paddr == OFF_COMPARE |-> prdata == cmp_sh; endproperty
    a_cmp: assert property (p_cmp) else $error("compare readback wrong");
    property p_cnt; rd_acc && paddr == OFF_COUNT && cnt_known && ctrl_sh == 32'h0 |-> prdata == cnt_sh; endproperty
    a_cnt: assert property (p_cnt) else $error("stopped count moved");
    property p_irq; !ctrl_sh[CTRL_IE] && !ctrl_sh[HALF_W + CTRL_IE] |-> !irq; endproperty
    a_irq: assert property (p_irq) else $error("irq without enable");
    property p_wake; !ctrl_sh[CTRL_WE] && !ctrl_sh[HALF_W + CTRL_WE] |-> !wake; endproperty
    a_wake: assert property (p_wake) else $error("wake without enable");
    property p_hold; ctrl_sh == 32'h0 |=> $stable(timer_out); endproperty
    a_hold: assert property (p_hold) else $error("output moved while stopped");
endmodule : reloadable_split_timer_checker

bind reloadable_split_timer reloadable_split_timer_checker u_reloadable_split_timer_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_out(timer_out),
    .irq(irq), .wake(wake));

// File: reloadable_split_timer_tb_top.sv
/* Self-checking testbench for the reloadable split timer.
   Assumes the APB slave answers without wait states and the pin model on the far side. */
`timescale 1ns/10ps
module reloadable_split_timer_tb_top
    import split_timer_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, wake, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, v, w;
    logic [1:0] timer_in, timer_out;
    int miscompares, n_compared, t0;
    reloadable_split_timer u_reloadable_split_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_in(timer_in), .timer_out(timer_out), .irq(irq), .wake(wake));
    timer_pin_model u_timer_pin_model (.pclk(pclk), .timer_out(timer_out), .timer_in(timer_in));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test
    // One APB transfer; read data and error are taken at the pready edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        v = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task bit_is(input logic b);
        check({31'h0, b}, 32'h1);
    endtask : bit_is
    // Timer is stopped before any register changes
    task cfg(input logic [1:0] arr, input logic [31:0] cnt, cmp, pw, ctl);
        apb(1'b1, OFF_CTRL, 32'h0);
        apb(1'b1, OFF_ARRANGE, {30'h0, arr});
        apb(1'b1, OFF_COUNT, cnt);
        apb(1'b1, OFF_COMPARE, cmp);
        apb(1'b1, OFF_PWIDTH, pw);
        apb(1'b1, OFF_FLAGS, 32'hFFFF_FFFF);
        apb(1'b1, OFF_CTRL, ctl);
    endtask : cfg
    initial begin
        repeat (40000) @(posedge pclk);
        miscompares++;
        end_of_test;
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        miscompares = 0;
        n_compared = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFF_COUNT, 32'h0); check(v, COUNT_RESET);
        apb(1'b0, OFF_COMPARE, 32'h0); check(v, COMPARE_RESET);
        apb(1'b0, OFF_DIVIDE, 32'h0); check(v, DIVIDE_RESET);
        apb(1'b0, 8'h1C, 32'h0); check(v, 32'h0); bit_is(e);
        apb(1'b1, 8'h02, 32'h5); bit_is(e);
        cfg(ARR_SINGLE32, 32'h1, 32'd100, 32'h0, 32'hC5);
        apb(1'b0, OFF_COUNT, 32'h0); w = v;
        apb(1'b0, OFF_COUNT, 32'h0); check(v - w, 32'd3);
        repeat (110) @(posedge pclk);
        apb(1'b0, OFF_FLAGS, 32'h0); check(v & 32'h1, 32'h1);
        bit_is(irq);
        bit_is(wake);
        apb(1'b1, OFF_CTRL, 32'h0);
        apb(1'b1, OFF_FLAGS, 32'h1);
        apb(1'b0, OFF_FLAGS, 32'h0); check(v, 32'h0);
        bit_is(!irq);
        cfg(ARR_SINGLE32, 32'h1, 32'd5, 32'h0, 32'h01);
        // Terminal value stands for one tick before the reload
        repeat (3) @(posedge pclk);
        apb(1'b0, OFF_COUNT, 32'h0); check(v, 32'd5);
        repeat (14) @(posedge pclk);
        apb(1'b0, OFF_COUNT, 32'h0); check(v, COUNT_RELOAD);
        apb(1'b0, OFF_CTRL, 32'h0); check(v, 32'h0);
        apb(1'b0, OFF_FLAGS, 32'h0); check(v, 32'h1);
        apb(1'b1, OFF_DIVIDE, 32'h0000_0FFF);
        cfg(ARR_SINGLE32, 32'h1, 32'd3, 32'h0, 32'h01);
        repeat (5000) @(posedge pclk);
        apb(1'b0, OFF_COUNT, 32'h0); check(v, 32'h2);
        repeat (8000) @(posedge pclk);
        apb(1'b0, OFF_FLAGS, 32'h0); check(v, 32'h1);
        apb(1'b1, OFF_CTRL, 32'h0);
        apb(1'b1, OFF_DIVIDE, 32'h0);
        cfg(ARR_SINGLE32, 32'h1, 32'h1000, 32'h0, 32'h0B);
        repeat (20) @(posedge pclk);
        apb(1'b0, OFF_COUNT, 32'h0); check(v, 32'h1);
        u_timer_pin_model.pulses(0, 5, 8, 8);
        apb(1'b0, OFF_COUNT, 32'h0); check(v, 32'h6);
        cfg(ARR_SINGLE32, 32'h1, 32'h1000, 32'h0, 32'h1B);
        repeat (30) @(posedge pclk);
        apb(1'b0, OFF_COUNT, 32'h0); check(v, 32'h1);
        u_timer_pin_model.pulses(0, 1, 40, 10);
        apb(1'b0, OFF_COUNT, 32'h0); bit_is(v > 32'd35 && v < 32'd46);
        cfg(ARR_SINGLE32, 32'h1, 32'hFFFF, 32'h0, 32'h13);
        repeat (30) @(posedge pclk);
        u_timer_pin_model.pulses(0, 1, 4, 10);
        apb(1'b0, OFF_PWIDTH, 32'h0); bit_is(v > 32'd25 && v < 32'd45);
        cfg(ARR_SINGLE32, 32'h1, 32'hFFFF, 32'h0, 32'h1F);
        u_timer_pin_model.pulses(0, 1, 20, 10);
        apb(1'b0, OFF_PWIDTH, 32'h0); bit_is(v > 32'd14 && v < 32'd30);
        cfg(ARR_SINGLE32, 32'h1, 32'd10, 32'd4, 32'h0D);
        t0 = u_timer_pin_model.toggles[0];
        repeat (100) @(posedge pclk);
        t0 = u_timer_pin_model.toggles[0] - t0;
        bit_is(t0 > 14 && t0 < 26);
        cfg(ARR_SINGLE32, 32'h1, 32'd10, 32'h0, 32'h15);
        t0 = u_timer_pin_model.toggles[0];
        repeat (30) @(posedge pclk);
        bit_is(u_timer_pin_model.toggles[0] > t0);
        cfg(ARR_DUAL16, 32'h0001_0001, 32'hFFFF_FFFF, 32'h0, 32'h0005_0000);
        repeat (20) @(posedge pclk);
        apb(1'b0, OFF_COUNT, 32'h0); check({16'h0, v[15:0]}, 32'h1);
        bit_is(v[31:16] > 16'd15 && v[31:16] < 16'd35);
        cfg(ARR_SINGLE16, 32'h0001_0001, 32'hFFFF_FFFF, 32'h0, 32'h0005_0005);
        repeat (20) @(posedge pclk);
        apb(1'b0, OFF_COUNT, 32'h0); check({16'h0, v[31:16]}, 32'h1);
        bit_is(v[15:0] > 16'd15);
        cfg(ARR_CASCADE32, 32'h0000_FFF0, 32'hFFFF_FFFF, 32'h0, 32'h0000_0005);
        repeat (30) @(posedge pclk);
        apb(1'b0, OFF_COUNT, 32'h0); check({16'h0, v[31:16]}, 32'h1);
        apb(1'b1, OFF_CTRL, 32'h0);
        end_of_test;
    end
endmodule : reloadable_split_timer_tb_top

// File: split_timer_pkg.sv
/*
 * Constants and types shared by the reloadable split timer.
 * Assumes a 32-bit APB register bus and one system clock.
 */
package split_timer_pkg;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFF_COUNT = 8'h00;
    localparam logic [7:0] OFF_COMPARE = 8'h04;
    localparam logic [7:0] OFF_PWIDTH = 8'h08;
    localparam logic [7:0] OFF_CTRL = 8'h0C;
    localparam logic [7:0] OFF_DIVIDE = 8'h10;
    localparam logic [7:0] OFF_ARRANGE = 8'h14;
    localparam logic [7:0] OFF_FLAGS = 8'h18;

    // ****************************************************************
    // Field layout, per 16-bit half of the control and divide registers
    // ****************************************************************
    localparam int HALF_W = 16;
    localparam int CTRL_EN = 0;
    localparam int CTRL_POL = 1;
    localparam int CTRL_MODE_LSB = 2;
    localparam int CTRL_IE = 6;
    localparam int CTRL_WE = 7;
    localparam int DIV_W = 12;

    // ****************************************************************
    // Reset and reload values
    // ****************************************************************
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
    localparam logic [31:0] COUNT_RELOAD = 32'h0000_0001;
    localparam logic [31:0] COMPARE_RESET = 32'hFFFF_FFFF;
    localparam logic [31:0] PWIDTH_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] DIVIDE_RESET = 32'h0000_0000;

    // ****************************************************************
    // Operating modes and counter arrangements
    // ****************************************************************
    localparam logic [3:0] MODE_ONESHOT = 4'h0;
    localparam logic [3:0] MODE_CONTINUOUS = 4'h1;
    localparam logic [3:0] MODE_COUNTER = 4'h2;
    localparam logic [3:0] MODE_PWM = 4'h3;
    localparam logic [3:0] MODE_CAPTURE = 4'h4;
    localparam logic [3:0] MODE_COMPARE = 4'h5;
    localparam logic [3:0] MODE_GATED = 4'h6;
    localparam logic [3:0] MODE_CAPCMP = 4'h7;

    localparam logic [1:0] ARR_SINGLE32 = 2'h0;
    localparam logic [1:0] ARR_CASCADE32 = 2'h1;
    localparam logic [1:0] ARR_DUAL16 = 2'h2;
    localparam logic [1:0] ARR_SINGLE16 = 2'h3;

    // Outcome of one timer step
    typedef struct packed {
        logic [31:0] cnt;
        logic [31:0] pw;
        logic outb;
        logic flag;
        logic stop;
    } step_t;

endpackage : split_timer_pkg

// File: timer_pin_model.sv
/* Far side of the timer: drives both input pins and counts output toggles.
   Assumes pulse requests arrive just after a rising pclk edge. */
`timescale 1ns/10ps
module timer_pin_model (
    // Clock
    input wire logic pclk,
    // Timer pins
    input wire logic [1:0] timer_out,
    output logic [1:0] timer_in
);
    int toggles [2];
    logic [1:0] last_out;
    initial begin
        timer_in = 2'h0;
        last_out = 2'h0;
    end
    always @(posedge pclk) begin
        for (int i = 0; i < 2; i++) begin
            if (timer_out[i] !== last_out[i]) toggles[i]++;
        end
        last_out <= timer_out;
    end
    // Levels last several ticks, since shorter pulses may be missed
    task pulses(input int idx, input int n, input int hi, input int lo);
        repeat (n) begin
            timer_in[idx] <= 1'b1;
            repeat (hi) @(posedge pclk);
            timer_in[idx] <= 1'b0;
            repeat (lo) @(posedge pclk);
        end
    endtask : pulses
endmodule : timer_pin_model
